// ---- crx_rx.sv ----
// camera link receiver: lane sequencing, settle, byte buffer and pixel packing
`timescale 1ns/100ps

// dual clock byte buffer with gray pointers
module crx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic wr_clk,
	input wire logic wr_reset,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_clk,
	input wire logic rd_reset,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [WIDTH-1:0] rd_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wbin_q, wgray_q, rbin_q, rgray_q;
	logic [AW:0] rgray_s1_q, rgray_s2_q, wgray_s1_q, wgray_s2_q;
	logic [AW:0] wbin_d, rbin_d;

	function automatic logic [AW:0] to_gray(input logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction

	assign wbin_d = wbin_q + {{AW{1'b0}}, 1'b1};
	assign rbin_d = rbin_q + {{AW{1'b0}}, 1'b1};
	// full when write gray equals read gray with top two bits flipped
	assign wr_ready = (wgray_q != {~rgray_s2_q[AW:AW-1], rgray_s2_q[AW-2:0]});
	assign rd_valid = (rgray_q != wgray_s2_q);
	assign rd_data = mem[rbin_q[AW-1:0]];

	// write side
	always_ff @(posedge wr_clk) begin
		if (wr_reset) begin
			wbin_q <= '0;
			wgray_q <= '0;
		end else if (wr_valid && wr_ready) begin
			wbin_q <= wbin_d;
			wgray_q <= to_gray(wbin_d);
		end
	end
	always_ff @(posedge wr_clk) begin
		if (wr_valid && wr_ready)
			mem[wbin_q[AW-1:0]] <= wr_data;
	end
	// read pointer into write domain
	always_ff @(posedge wr_clk) begin
		if (wr_reset) begin
			rgray_s1_q <= '0;
			rgray_s2_q <= '0;
		end else begin
			rgray_s1_q <= rgray_q;
			rgray_s2_q <= rgray_s1_q;
		end
	end
	// read side
	always_ff @(posedge rd_clk) begin
		if (rd_reset) begin
			rbin_q <= '0;
			rgray_q <= '0;
		end else if (rd_valid && rd_ready) begin
			rbin_q <= rbin_d;
			rgray_q <= to_gray(rbin_d);
		end
	end
	// write pointer into read domain
	always_ff @(posedge rd_clk) begin
		if (rd_reset) begin
			wgray_s1_q <= '0;
			wgray_s2_q <= '0;
		end else begin
			wgray_s1_q <= wgray_q;
			wgray_s2_q <= wgray_s1_q;
		end
	end
endmodule

module crx_rx #(
	parameter int UI_PS = crx_pkg::UI_PS_DEFAULT
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_link,
	input wire logic [1:0] clk_lane_lp,
	input wire logic [1:0] data_lane_lp,
	input wire logic [7:0] hs_byte,
	input wire logic hs_byte_valid,
	input wire logic [5:0] type_code,
	input wire logic line_sync,
	output logic [63:0] px_data,
	output logic [3:0] px_count,
	output logic px_valid,
	input wire logic px_ready,
	output logic px_line_odd,
	output logic [5:0] type_active,
	output logic type_known,
	output logic clk_lane_hs,
	output logic data_lane_hs,
	output logic overflow
);
	// data settle: least point rounds up, must stay below the latest point
	localparam int HS_SETTLE_CYC = (crx_pkg::HS_SETTLE_MIN_NS * 1000 + crx_pkg::HS_SETTLE_MIN_UI * UI_PS
		+ crx_pkg::CLK_PS - 1) / crx_pkg::CLK_PS;
	localparam logic [7:0] HS_SETTLE = 8'(HS_SETTLE_CYC);
	localparam logic [7:0] CLK_SETTLE = 8'(crx_pkg::CLK_SETTLE_CYC);

	typedef enum logic [1:0] {
		LN_STOP = 2'b00,
		LN_REQ = 2'b01,
		LN_PREP = 2'b10,
		LN_HS = 2'b11
	} crx_lane_t;

	// bytes per beat and pixels per beat for a type code and line parity
	function automatic logic [7:0] beat_info(input logic [5:0] t, input logic odd);
		logic [3:0] nb, np;
		nb = 4'h0;
		np = 4'h0;
		if (t >= crx_pkg::TYPE_RGB_FIRST && t <= crx_pkg::TYPE_RGB_LAST) begin
			case (t)
				6'h20: begin nb = 4'h6; np = 4'h4; end
				6'h21: begin nb = 4'h8; np = 4'h4; end
				6'h22: begin nb = 4'h8; np = 4'h4; end
				6'h23: begin nb = 4'h7; np = 4'h3; end
				default: begin nb = 4'h6; np = 4'h2; end
			endcase
		end else if (t >= crx_pkg::TYPE_RAW_FIRST && t <= crx_pkg::TYPE_RAW_LAST) begin
			case (t)
				6'h28: begin nb = 4'h6; np = 4'h8; end
				6'h29: begin nb = 4'h7; np = 4'h8; end
				6'h2a: begin nb = 4'h8; np = 4'h8; end
				6'h2b: begin nb = 4'h5; np = 4'h4; end
				6'h2c: begin nb = 4'h6; np = 4'h4; end
				default: begin nb = 4'h7; np = 4'h4; end
			endcase
		end else if (t >= crx_pkg::TYPE_USER_FIRST && t <= crx_pkg::TYPE_USER_LAST) begin
			nb = 4'h8;
			np = 4'h8;
		end else if (t == crx_pkg::TYPE_YUV8 || t == crx_pkg::TYPE_YUV8_CSPS) begin
			nb = 4'h8;
			np = odd ? 4'h8 : 4'h4;
		end else if (t == crx_pkg::TYPE_YUV10 || t == crx_pkg::TYPE_YUV10_CSPS) begin
			nb = 4'h5;
			np = odd ? 4'h4 : 4'h2;
		end else if (t == crx_pkg::TYPE_YUV8_LEGACY) begin
			nb = 4'h6;
			np = 4'h4;
		end else if (t == crx_pkg::TYPE_YUV422_8) begin
			nb = 4'h8;
			np = 4'h4;
		end else if (t == crx_pkg::TYPE_YUV422_10) begin
			nb = 4'h5;
			np = 4'h2;
		end
		return {nb, np};
	endfunction

	// lane sequencer with settle counter, shared by clock and data lanes
	function automatic logic [9:0] lane_next(input logic [1:0] st, input logic [7:0] cnt,
		input logic [1:0] lp, input logic [7:0] settle);
		logic [1:0] ns;
		logic [7:0] nc;
		ns = st;
		nc = cnt;
		case (crx_lane_t'(st))
			LN_STOP: if (lp == crx_pkg::LP01) ns = LN_REQ;
			LN_REQ: begin
				if (lp == crx_pkg::LP00) begin
					ns = LN_PREP;
					nc = 8'h01;
				end else if (lp == crx_pkg::LP11) begin
					ns = LN_STOP;
				end
			end
			LN_PREP: begin
				if (lp == crx_pkg::LP11) ns = LN_STOP;
				else if (cnt >= settle) ns = LN_HS;
				else nc = cnt + 8'h01;
			end
			LN_HS: if (lp == crx_pkg::LP11) ns = LN_STOP;
			default: ns = LN_STOP;
		endcase
		return {ns, nc};
	endfunction

	logic [1:0] clp_s1_q, clp_s2_q, dlp_s1_q, dlp_s2_q;
	logic [1:0] clk_st_q, dat_st_q;
	logic [7:0] clk_cnt_q, dat_cnt_q;
	logic [9:0] clk_nx, dat_nx;
	logic rst_l1_q, rst_l2_q, en_l1_q, en_l2_q, ovf_l_q, ovf_s1_q, ovf_s2_q;
	logic wr_ready, rd_valid, rd_ready;
	logic [7:0] rd_data;
	logic [63:0] acc_q;
	logic [3:0] acc_n_q, need;
	logic [7:0] info;
	logic line_q, line_odd_q, lane_hs_q, clk_hs_q, out_free;
	logic [5:0] type_q;

	// low-power pins come from the far end: two flops first
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			clp_s1_q <= crx_pkg::LP11;
			clp_s2_q <= crx_pkg::LP11;
			dlp_s1_q <= crx_pkg::LP11;
			dlp_s2_q <= crx_pkg::LP11;
		end else begin
			clp_s1_q <= clk_lane_lp;
			clp_s2_q <= clp_s1_q;
			dlp_s1_q <= data_lane_lp;
			dlp_s2_q <= dlp_s1_q;
		end
	end

	assign clk_nx = lane_next(clk_st_q, clk_cnt_q, clp_s2_q, CLK_SETTLE);
	assign dat_nx = lane_next(dat_st_q, dat_cnt_q, dlp_s2_q, HS_SETTLE);

	// clock lane: ignore transitions for the settle time after LP-00
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			clk_st_q <= LN_STOP;
			clk_cnt_q <= 8'h00;
		end else begin
			clk_st_q <= clk_nx[9:8];
			clk_cnt_q <= clk_nx[7:0];
		end
	end
	// data lane: ignore transitions before the data settle time
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			dat_st_q <= LN_STOP;
			dat_cnt_q <= 8'h00;
		end else begin
			dat_st_q <= dat_nx[9:8];
			dat_cnt_q <= dat_nx[7:0];
		end
	end
	// data only counts while the clock lane is running too
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			clk_hs_q <= 1'b0;
			lane_hs_q <= 1'b0;
		end else begin
			clk_hs_q <= (clk_st_q == LN_HS);
			lane_hs_q <= (dat_st_q == LN_HS) && (clk_st_q == LN_HS);
		end
	end

	// reset and receive enable into the link domain
	always_ff @(posedge clk_link) begin
		rst_l1_q <= reset;
		rst_l2_q <= rst_l1_q;
	end
	always_ff @(posedge clk_link) begin
		if (rst_l2_q) begin
			en_l1_q <= 1'b0;
			en_l2_q <= 1'b0;
		end else begin
			en_l1_q <= lane_hs_q;
			en_l2_q <= en_l1_q;
		end
	end
	// sticky drop flag when the buffer is full
	always_ff @(posedge clk_link) begin
		if (rst_l2_q)
			ovf_l_q <= 1'b0;
		else if (en_l2_q && hs_byte_valid && !wr_ready)
			ovf_l_q <= 1'b1;
	end
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ovf_s1_q <= 1'b0;
			ovf_s2_q <= 1'b0;
		end else begin
			ovf_s1_q <= ovf_l_q;
			ovf_s2_q <= ovf_s1_q;
		end
	end

	crx_fifo #(.WIDTH(crx_pkg::FIFO_W), .DEPTH(crx_pkg::FIFO_DEPTH)) u_fifo (
		.wr_clk(clk_link),
		.wr_reset(rst_l2_q),
		.wr_valid(en_l2_q && hs_byte_valid),
		.wr_ready(wr_ready),
		.wr_data(hs_byte),
		.rd_clk(clk_sys),
		.rd_reset(reset),
		.rd_valid(rd_valid),
		.rd_ready(rd_ready),
		.rd_data(rd_data)
	);

	// type changes only while line sync is low; line parity flips per line
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			type_q <= crx_pkg::TYPE_RESET;
			line_q <= 1'b0;
			line_odd_q <= 1'b1;
		end else begin
			line_q <= line_sync;
			if (!line_sync)
				type_q <= type_code;
			if (line_q && !line_sync)
				line_odd_q <= ~line_odd_q;
		end
	end

	assign info = beat_info(type_q, line_odd_q);
	assign need = info[7:4];
	assign out_free = !px_valid || px_ready;
	// stall the buffer while a full beat waits for the core
	assign rd_ready = (acc_n_q < need) && (need != 4'h0);

	// collect bytes, low byte first, and hand a beat out when complete
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			acc_q <= '0;
			acc_n_q <= 4'h0;
			px_valid <= 1'b0;
			px_data <= '0;
			px_count <= 4'h0;
			px_line_odd <= 1'b1;
		end else begin
			if (px_valid && px_ready)
				px_valid <= 1'b0;
			if (rd_valid && rd_ready) begin
				acc_q[acc_n_q[2:0]*8 +: 8] <= rd_data;
				acc_n_q <= acc_n_q + 4'h1;
			end else if (acc_n_q >= need && need != 4'h0 && out_free) begin
				px_valid <= 1'b1;
				px_data <= acc_q;
				px_count <= info[3:0];
				px_line_odd <= line_odd_q;
				acc_q <= '0;
				acc_n_q <= 4'h0;
			end
		end
	end

	// status outputs
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			type_active <= crx_pkg::TYPE_RESET;
			type_known <= 1'b1;
			clk_lane_hs <= 1'b0;
			data_lane_hs <= 1'b0;
			overflow <= 1'b0;
		end else begin
			type_active <= type_q;
			type_known <= (need != 4'h0);
			clk_lane_hs <= clk_hs_q;
			data_lane_hs <= lane_hs_q;
			overflow <= ovf_s2_q;
		end
	end
endmodule

// ---- crx_pkg.sv ----
// shared constants for the camera link receiver
package crx_pkg;
	// lane line states as {dp, dn}
	localparam logic [1:0] LP11 = 2'h3;
	localparam logic [1:0] LP01 = 2'h1;
	localparam logic [1:0] LP00 = 2'h0;
	// video type code ranges and fields
	localparam logic [5:0] TYPE_RGB_FIRST = 6'h20;
	localparam logic [5:0] TYPE_RGB_LAST = 6'h24;
	localparam logic [5:0] TYPE_RAW_FIRST = 6'h28;
	localparam logic [5:0] TYPE_RAW_LAST = 6'h2d;
	localparam logic [5:0] TYPE_USER_FIRST = 6'h30;
	localparam logic [5:0] TYPE_USER_LAST = 6'h37;
	localparam logic [5:0] TYPE_YUV8 = 6'h18;
	localparam logic [5:0] TYPE_YUV10 = 6'h19;
	localparam logic [5:0] TYPE_YUV8_LEGACY = 6'h1a;
	localparam logic [5:0] TYPE_YUV8_CSPS = 6'h1c;
	localparam logic [5:0] TYPE_YUV10_CSPS = 6'h1d;
	localparam logic [5:0] TYPE_YUV422_8 = 6'h1e;
	localparam logic [5:0] TYPE_YUV422_10 = 6'h1f;
	localparam logic [5:0] TYPE_RESET = 6'h2a;
	// receiver timing, system clock period in ps
	localparam int CLK_PS = 5000;
	localparam int UI_PS_DEFAULT = 2000;
	localparam int CLK_SETTLE_MIN_NS = 95;
	localparam int CLK_SETTLE_MAX_NS = 300;
	localparam int HS_SETTLE_MIN_NS = 85;
	localparam int HS_SETTLE_MIN_UI = 6;
	localparam int HS_SETTLE_MAX_NS = 145;
	localparam int HS_SETTLE_MAX_UI = 10;
	// least settle rounds up to whole cycles
	localparam int CLK_SETTLE_CYC = (CLK_SETTLE_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int CNT_W = 8;
	// buffer shape
	localparam int FIFO_W = 8;
	localparam int FIFO_DEPTH = 32;
	localparam int PX_W = 64;
	localparam int BEAT_W = 4;
endpackage

// ---- crx_rx_checker.sv ----
// port checker for the camera link receiver
`timescale 1ns/100ps
module crx_rx_checker (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [1:0] clk_lane_lp,
	input wire logic [1:0] data_lane_lp,
	input wire logic line_sync,
	input wire logic [63:0] px_data,
	input wire logic [3:0] px_count,
	input wire logic px_valid,
	input wire logic px_ready,
	input wire logic px_line_odd,
	input wire logic [5:0] type_active,
	input wire logic type_known,
	input wire logic clk_lane_hs,
	input wire logic data_lane_hs,
	input wire logic overflow
);
	logic [5:0] lp00_q;
	// pixels per beat, zero for codes that cannot be packed
	function automatic logic [3:0] px_of(logic [5:0] t, logic odd);
		case (t) inside
			6'h20, 6'h21, 6'h22, 6'h1a, 6'h1e, [6'h2b:6'h2d]: px_of = 4'h4;
			6'h23: px_of = 4'h3;
			6'h24, 6'h1f: px_of = 4'h2;
			[6'h28:6'h2a], [6'h30:6'h37]: px_of = 4'h8;
			6'h18, 6'h1c: px_of = odd ? 4'h8 : 4'h4;
			6'h19, 6'h1d: px_of = odd ? 4'h4 : 4'h2;
			default: px_of = 4'h0;
		endcase
	endfunction
	// run length of lp-00 on the data lane pins
	always_ff @(posedge clk_sys) begin
		if (reset || data_lane_lp != crx_pkg::LP00) begin
			lp00_q <= 6'h00;
		end else if (lp00_q != 6'h3f) begin
			lp00_q <= lp00_q + 6'h01;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	chk_reset_state: assert property (disable iff (1'b0) reset |=> type_active == 6'h2a && type_known
		&& !px_valid && !overflow && !data_lane_hs) else $error("reset state wrong");
	chk_beat_hold: assert property (px_valid && !px_ready |=> px_valid && $stable(px_data))
		else $error("beat dropped before accept");
	chk_type_frozen: assert property (line_sync [*3] |=> $stable(type_active))
		else $error("type moved while line sync high");
	chk_type_known: assert property ($stable(type_active) [*2] |-> type_known == (px_of(type_active, 1'b1) != 0))
		else $error("type known flag wrong");
	chk_pixel_count: assert property (px_valid && type_known |-> px_count == px_of(type_active, px_line_odd))
		else $error("pixel count wrong");
	chk_clock_first: assert property (data_lane_hs |-> clk_lane_hs)
		else $error("data lane high speed without clock lane");
	chk_clock_exit: assert property (clk_lane_lp == crx_pkg::LP11 [*8] |-> !clk_lane_hs)
		else $error("clock lane kept high speed after stop state");
	chk_settle_early: assert property ($rose(data_lane_hs) |-> $past(data_lane_lp, 20) == crx_pkg::LP00)
		else $error("data lane settled too soon");
	chk_settle_late: assert property (lp00_q == 6'd40 && clk_lane_hs |-> data_lane_hs)
		else $error("data lane settled too late");
endmodule
bind crx_rx crx_rx_checker crx_rx_checker_inst (.clk_sys(clk_sys), .reset(reset), .clk_lane_lp(clk_lane_lp),
	.data_lane_lp(data_lane_lp), .line_sync(line_sync), .px_data(px_data), .px_count(px_count),
	.px_valid(px_valid), .px_ready(px_ready), .px_line_odd(px_line_odd), .type_active(type_active),
	.type_known(type_known), .clk_lane_hs(clk_lane_hs), .data_lane_hs(data_lane_hs), .overflow(overflow));

// ---- crx_sensor.sv ----
// camera sensor model: lane sequencing and link bytes
`timescale 1ns/100ps
module crx_sensor (
	input wire logic reset,
	output logic clk_link,
	output logic [1:0] clk_lane_lp,
	output logic [1:0] data_lane_lp,
	output logic [7:0] hs_byte,
	output logic hs_byte_valid
);
	logic on = 1'b0;
	// idle lines at time zero
	initial begin
		clk_link = 1'b0;
		clk_lane_lp = crx_pkg::LP11;
		data_lane_lp = crx_pkg::LP11;
		hs_byte = 8'h00;
		hs_byte_valid = 1'b0;
	end
	// link clock runs in reset and bursts only, low otherwise
	always begin
		#7.5;
		clk_link = (reset || on) ? ~clk_link : 1'b0;
	end
	// one burst of n bytes counting up from b0
	task automatic burst(int n, logic [7:0] b0);
		clk_lane_lp = crx_pkg::LP01;
		#60 clk_lane_lp = crx_pkg::LP00;
		#60;
		#240 on = 1'b1;
		#30 data_lane_lp = crx_pkg::LP01;
		#60 data_lane_lp = crx_pkg::LP00;
		#60;
		#200;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_link);
			hs_byte <= b0 + 8'(i);
			hs_byte_valid <= 1'b1;
		end
		@(posedge clk_link);
		hs_byte_valid <= 1'b0;
		hs_byte <= ~hs_byte; // released bus shows no stale byte
		#70 data_lane_lp = crx_pkg::LP11;
		#170 on = 1'b0;
		#60 clk_lane_lp = crx_pkg::LP11;
		#60;
	endtask
endmodule

// ---- tb_top.sv ----
// self-checking bench for the camera link receiver
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic clk_link, hs_byte_valid, px_valid, px_line_odd, type_known, clk_lane_hs, data_lane_hs, overflow;
	logic [1:0] clk_lane_lp, data_lane_lp;
	logic [7:0] hs_byte;
	logic [5:0] type_code = 6'h2a;
	logic [5:0] type_active;
	logic line_sync = 1'b0;
	logic px_ready = 1'b0;
	logic [63:0] px_data;
	logic [3:0] px_count;
	int err_count = 0;
	int n_compared = 0;
	// system clock
	always #2.5 clk_sys = ~clk_sys;
	crx_rx #(.UI_PS(2000)) crx_rx_inst (.clk_sys(clk_sys), .reset(reset), .clk_link(clk_link),
		.clk_lane_lp(clk_lane_lp), .data_lane_lp(data_lane_lp), .hs_byte(hs_byte), .hs_byte_valid(hs_byte_valid),
		.type_code(type_code), .line_sync(line_sync), .px_data(px_data), .px_count(px_count), .px_valid(px_valid),
		.px_ready(px_ready), .px_line_odd(px_line_odd), .type_active(type_active), .type_known(type_known),
		.clk_lane_hs(clk_lane_hs), .data_lane_hs(data_lane_hs), .overflow(overflow));
	crx_sensor crx_sensor_inst (.reset(reset), .clk_link(clk_link), .clk_lane_lp(clk_lane_lp),
		.data_lane_lp(data_lane_lp), .hs_byte(hs_byte), .hs_byte_valid(hs_byte_valid));
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// type changes only with line sync low
	task automatic set_type(logic [5:0] t);
		@(posedge clk_sys);
		type_code <= t;
		repeat (4) @(posedge clk_sys);
	endtask
	// line sync pulse, falling edge flips parity
	task automatic line_pulse();
		@(posedge clk_sys);
		line_sync <= 1'b1;
		repeat (3) @(posedge clk_sys);
		line_sync <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	// wait for a beat with a stall, judge it, accept it
	task automatic take(int n, logic [7:0] b, logic [3:0] cnt, logic odd);
		logic [63:0] e;
		int i;
		e = 64'h0;
		for (i = 0; i < n; i++) e[8*i+:8] = b + 8'(i);
		for (i = 0; i < 900 && px_valid !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
		if (i == 900) begin
			err_count++;
			final_report();
		end
		repeat (2) @(posedge clk_sys);
		`CHK("px_data", e, px_data)
		`CHK("px_count", cnt, px_count)
		`CHK("px_line_odd", odd, px_line_odd)
		px_ready <= 1'b1;
		@(posedge clk_sys);
		px_ready <= 1'b0;
		#1;
	endtask
	task automatic t_raw();
		crx_sensor_inst.burst(8, 8'h10);
		take(8, 8'h10, 4'h8, 1'b1);
		set_type(6'h2b);
		crx_sensor_inst.burst(5, 8'h20);
		take(5, 8'h20, 4'h4, 1'b1);
	endtask
	task automatic t_yuv();
		set_type(6'h18);
		crx_sensor_inst.burst(8, 8'h30);
		take(8, 8'h30, 4'h8, 1'b1);
		line_pulse();
		crx_sensor_inst.burst(8, 8'h40);
		take(8, 8'h40, 4'h4, 1'b0);
		set_type(6'h1d);
		crx_sensor_inst.burst(5, 8'h48);
		take(5, 8'h48, 4'h2, 1'b0);
		line_pulse();
		crx_sensor_inst.burst(5, 8'h4d);
		take(5, 8'h4d, 4'h4, 1'b1);
	endtask
	task automatic t_types();
		logic [5:0] c[8] = '{6'h00, 6'h1b, 6'h20, 6'h24, 6'h2d, 6'h2e, 6'h30, 6'h37};
		logic [7:0] k = 8'b1101_1100;
		for (int i = 0; i < 8; i++) begin
			set_type(c[i]);
			`CHK("type_active", c[i], type_active)
			`CHK("type_known", k[i], type_known)
		end
	endtask
	// unknown type stalls the buffer until it refuses, then drain it
	task automatic t_fill();
		set_type(6'h00);
		crx_sensor_inst.burst(40, 8'h50);
		repeat (10) @(posedge clk_sys);
		`CHK("overflow", 1'b1, overflow)
		set_type(6'h2a);
		for (int j = 0; j < 4; j++) take(8, 8'h50 + 8'(8*j), 4'h8, 1'b1);
	endtask
	// main sequence, reset long enough for the link domain
	initial begin
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		#1;
		`CHK("type_active", 6'h2a, type_active)
		`CHK("type_known", 1'b1, type_known)
		t_raw();
		t_yuv();
		t_types();
		t_fill();
		final_report();
	end
endmodule
